// [slbcfg_pkg.sv]
/*
  Constants, field layouts, reset values and enumerations for the
  second time slot front-end configuration bank. Assumes a 25 MHz
  clock and an AXI4-Lite host with 32-bit data.
*/
package slbcfg_pkg;
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  localparam logic [7:0] IDX_WIN = 8'h3b;
  localparam logic [7:0] IDX_MODE_GAIN = 8'h44;
  localparam logic [7:0] IDX_PATH = 8'h45;
  localparam logic [7:0] IDX_CH_GAIN = 8'h55;
  localparam logic [7:0] IDX_DIG_EN = 8'h58;
  localparam logic [7:0] IDX_GAP = 8'h5a;
  localparam logic [7:0] IDX_STATUS = 8'h60;
  localparam int WIDTH_LSB = 11;
  localparam int COARSE_LSB = 5;
  localparam int FINE_LSB = 0;
  localparam logic [4:0] WIDTH_RST = 5'h04;
  localparam logic [5:0] COARSE_RST = 6'h17;
  localparam logic [4:0] FINE_RST = 5'h1c;
  localparam logic [15:0] WIN_RST = {WIDTH_RST, COARSE_RST, FINE_RST};
  localparam int MODE_LSB = 8;
  localparam int IND_EN_BIT = 6;
  localparam int GAIN_LSB = 0;
  localparam logic [7:0] MODE_CODE_NORMAL = 8'h1c;
  localparam logic [7:0] MODE_CODE_DIGINT = 8'h1d;
  localparam logic [15:0] MODE_GAIN_RST = 16'h1c38;
  localparam logic [15:0] PATH_CODE_FULL = 16'hada5;
  localparam logic [15:0] PATH_CODE_AMP = 16'hb065;
  localparam logic [15:0] PATH_CODE_DIGINT = 16'hae65;
  localparam logic [15:0] PATH_RST = PATH_CODE_FULL;
  localparam int CH_GAIN_LSB = 6;
  localparam logic [15:0] CH_GAIN_RST = 16'h0000;
  localparam int DIG_EN_B_BIT = 13;
  localparam int DIG_EN_A_BIT = 12;
  localparam logic [15:0] DIG_EN_RST = 16'h0000;
  localparam int GAP_EN_BIT = 7;
  localparam logic [15:0] GAP_RST = 16'h0000;
  localparam int ST_PATH_LSB = 0;
  localparam int ST_MODE_LSB = 2;
  localparam int ST_OK_BIT = 4;
  localparam int ST_DIG_B_BIT = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_PERIOD_NS = 40;
  localparam int STEP_US_NS = 1000;
  localparam real FINE_STEP_NS = 31.25;
  localparam int FINE_PER_US = int'(STEP_US_NS / FINE_STEP_NS);
  localparam int CYC_PER_US = STEP_US_NS / CLK_PERIOD_NS;
  localparam int NUM_CH = 4;
  typedef enum logic [1:0] {
    PATH_FULL,
    PATH_AMP_ADC,
    PATH_DIGINT,
    PATH_RESERVED
  } slbcfg_path_t;
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_DIGINT,
    MODE_RESERVED
  } slbcfg_mode_t;
endpackage

// [slbcfg_gain_if.sv]
/*
  Gain settings passed from the register bank to the channel gain
  stage. Assumes both ends share one clock.
*/
`timescale 1ns/1ns
interface slbcfg_gain_if;
  logic ind_en;
  logic [1:0] shared_gain;
  logic [5:0] gain_234;
  logic [7:0] ch_gain;
  modport cfg (output ind_en, output shared_gain, output gain_234,
    input ch_gain);
  modport gain (input ind_en, input shared_gain, input gain_234,
    output ch_gain);
endinterface

// [slbcfg_gain.sv]
/*
  Per-channel transimpedance gain selection for the second slot.
  Assumes its settings come from registers on the same clock.
*/
`timescale 1ns/1ns
module slbcfg_gain (
  input wire logic i_clk,
  input wire logic i_rst_n,
  slbcfg_gain_if.gain g
);
  import slbcfg_pkg::*;

  // Channel 1 never reads the per-channel field, so it has no select
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : gen_ch
    if (ch == 0) begin : gen_first
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          g.ch_gain[1:0] <= 2'h0;
        end else begin
          g.ch_gain[1:0] <= g.shared_gain;
        end
      end
    end else begin : gen_other
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          g.ch_gain[2*ch +: 2] <= 2'h0;
        end else if (!g.ind_en) begin
          g.ch_gain[2*ch +: 2] <= g.shared_gain;
        end else begin
          g.ch_gain[2*ch +: 2] <= g.gain_234[2*(ch-1) +: 2];
        end
      end
    end
  end
endmodule

// [slbcfg_top.sv]
/*
  Second time slot front-end configuration bank with an AXI4-Lite
  slave. Assumes a single-clock host that keeps at most one write
  and one read under way; decoded outputs lag register writes by
  one clock.
*/
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ns
module slbcfg_top (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic [slbcfg_pkg::ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [slbcfg_pkg::ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [4:0] O_WIN_WIDTH_US,
  output logic [9:0] O_WIN_WIDTH_CYC,
  output logic [5:0] O_WIN_COARSE_US,
  output logic [4:0] O_WIN_FINE,
  output logic [10:0] O_WIN_START_FINE,
  output logic O_GAP_EN,
  output logic [9:0] O_GAP_CYC,
  output slbcfg_pkg::slbcfg_mode_t O_MODE,
  output slbcfg_pkg::slbcfg_path_t O_PATH,
  output logic [7:0] O_CH_GAIN,
  output logic O_DIGINT_A,
  output logic O_DIGINT_B,
  output logic O_CFG_OK
);
  import slbcfg_pkg::*;

  logic [15:0] win_reg;
  logic [15:0] mode_gain_reg;
  logic [15:0] path_reg;
  logic [15:0] ch_gain_reg;
  logic [15:0] dig_en_reg;
  logic [15:0] gap_reg;
  logic [15:0] status_word;

  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [7:0] wr_idx;
  logic wr_page_ok;
  logic wr_hit;

  logic [7:0] rd_idx;
  logic rd_page_ok;
  logic [15:0] rd_word;
  logic rd_hit;

  logic [4:0] width_f;
  logic [5:0] coarse_f;
  logic [4:0] fine_f;
  logic [7:0] mode_f;
  slbcfg_mode_t next_mode;
  slbcfg_path_t next_path;
  logic next_ok;

  slbcfg_gain_if gif ();

  function automatic logic [15:0] merge(input logic [15:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // Write address channel; ready stays low until the response is taken
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_AWREADY <= 1'b1;
    end else if (O_AWREADY && I_AWVALID) begin
      O_AWREADY <= 1'b0;
    end else if (O_BVALID && I_BREADY) begin
      O_AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (O_AWREADY && I_AWVALID) begin
      aw_held <= 1'b1;
      aw_addr <= I_AWADDR;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // Write data channel, taken independently of the address
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_WREADY <= 1'b1;
    end else if (O_WREADY && I_WVALID) begin
      O_WREADY <= 1'b0;
    end else if (O_BVALID && I_BREADY) begin
      O_WREADY <= 1'b1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (O_WREADY && I_WVALID) begin
      w_held <= 1'b1;
      w_data <= I_WDATA;
      w_strb <= I_WSTRB;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  assign do_write = aw_held && w_held && !O_BVALID;
  assign wr_idx = aw_addr[IDX_MSB:IDX_LSB];
  assign wr_page_ok = (aw_addr[ADDR_W-1:IDX_MSB+1] == '0);

  always_comb begin
    wr_hit = 1'b0;
    if (wr_page_ok) begin
      unique case (wr_idx)
        IDX_WIN, IDX_MODE_GAIN, IDX_PATH, IDX_CH_GAIN,
        IDX_DIG_EN, IDX_GAP, IDX_STATUS: wr_hit = 1'b1;
        default: wr_hit = 1'b0;
      endcase
    end
  end

  // Write response; unmapped addresses answer with an error
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_BVALID <= 1'b0;
      O_BRESP <= RESP_OKAY;
    end else if (do_write) begin
      O_BVALID <= 1'b1;
      O_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (I_BREADY) begin
      O_BVALID <= 1'b0;
    end
  end

  // Window timing register
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      win_reg <= WIN_RST;
    end else if (do_write && wr_page_ok && wr_idx == IDX_WIN) begin
      win_reg <= merge(win_reg, w_data, w_strb);
    end
  end

  // Mode code, gain enable and shared gain; reserved bits stay writable
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      mode_gain_reg <= MODE_GAIN_RST;
    end else if (do_write && wr_page_ok && wr_idx == IDX_MODE_GAIN) begin
      mode_gain_reg <= merge(mode_gain_reg, w_data, w_strb);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      path_reg <= PATH_RST;
    end else if (do_write && wr_page_ok && wr_idx == IDX_PATH) begin
      path_reg <= merge(path_reg, w_data, w_strb);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      ch_gain_reg <= CH_GAIN_RST;
    end else if (do_write && wr_page_ok && wr_idx == IDX_CH_GAIN) begin
      ch_gain_reg <= merge(ch_gain_reg, w_data, w_strb);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      dig_en_reg <= DIG_EN_RST;
    end else if (do_write && wr_page_ok && wr_idx == IDX_DIG_EN) begin
      dig_en_reg <= merge(dig_en_reg, w_data, w_strb);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      gap_reg <= GAP_RST;
    end else if (do_write && wr_page_ok && wr_idx == IDX_GAP) begin
      gap_reg <= merge(gap_reg, w_data, w_strb);
    end
  end

  // Read channel: one access at a time, data one clock after address
  assign rd_idx = I_ARADDR[IDX_MSB:IDX_LSB];
  assign rd_page_ok = (I_ARADDR[ADDR_W-1:IDX_MSB+1] == '0);

  assign status_word = {10'h000, O_DIGINT_B, O_CFG_OK, O_MODE, O_PATH};

  always_comb begin
    rd_word = 16'h0000;
    rd_hit = rd_page_ok;
    unique case (rd_idx)
      IDX_WIN: rd_word = win_reg;
      IDX_MODE_GAIN: rd_word = mode_gain_reg;
      IDX_PATH: rd_word = path_reg;
      IDX_CH_GAIN: rd_word = ch_gain_reg;
      IDX_DIG_EN: rd_word = dig_en_reg;
      IDX_GAP: rd_word = gap_reg;
      IDX_STATUS: rd_word = status_word;
      default: rd_hit = 1'b0;
    endcase
    if (!rd_page_ok) begin
      rd_word = 16'h0000;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_ARREADY <= 1'b1;
    end else if (O_ARREADY && I_ARVALID) begin
      O_ARREADY <= 1'b0;
    end else if (O_RVALID && I_RREADY) begin
      O_ARREADY <= 1'b1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_RVALID <= 1'b0;
      O_RDATA <= '0;
      O_RRESP <= RESP_OKAY;
    end else if (O_ARREADY && I_ARVALID) begin
      O_RVALID <= 1'b1;
      O_RDATA <= {16'h0000, rd_word};
      O_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (I_RREADY) begin
      O_RVALID <= 1'b0;
    end
  end

  // Field extraction
  assign width_f = win_reg[WIDTH_LSB +: 5];
  assign coarse_f = win_reg[COARSE_LSB +: 6];
  assign fine_f = win_reg[FINE_LSB +: 5];
  assign mode_f = mode_gain_reg[MODE_LSB +: 8];

  // Window placement; the start is kept in fine steps so that coarse
  // and fine offsets add without rounding
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_WIN_WIDTH_US <= WIDTH_RST;
      O_WIN_WIDTH_CYC <= 10'(int'(WIDTH_RST) * CYC_PER_US);
    end else begin
      O_WIN_WIDTH_US <= width_f;
      O_WIN_WIDTH_CYC <= 10'(int'(width_f) * CYC_PER_US);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_WIN_COARSE_US <= COARSE_RST;
      O_WIN_FINE <= FINE_RST;
      O_WIN_START_FINE <= 11'(int'(COARSE_RST) * FINE_PER_US
        + int'(FINE_RST));
    end else begin
      O_WIN_COARSE_US <= coarse_f;
      O_WIN_FINE <= fine_f;
      O_WIN_START_FINE <= 11'(int'(coarse_f) * FINE_PER_US
        + int'(fine_f));
    end
  end

  // Gap reuses the fine field, but read in whole microseconds
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_GAP_EN <= 1'b0;
      O_GAP_CYC <= 10'h000;
    end else begin
      O_GAP_EN <= gap_reg[GAP_EN_BIT];
      if (gap_reg[GAP_EN_BIT]) begin
        O_GAP_CYC <= 10'(int'(fine_f) * CYC_PER_US);
      end else begin
        O_GAP_CYC <= 10'h000;
      end
    end
  end

  // Mode code decode
  always_comb begin
    unique case (mode_f)
      MODE_CODE_NORMAL: next_mode = MODE_NORMAL;
      MODE_CODE_DIGINT: next_mode = MODE_DIGINT;
      default: next_mode = MODE_RESERVED;
    endcase
  end

  // Path code decode; reserved codes are flagged, not remapped
  always_comb begin
    unique case (path_reg)
      PATH_CODE_FULL: next_path = PATH_FULL;
      PATH_CODE_AMP: next_path = PATH_AMP_ADC;
      PATH_CODE_DIGINT: next_path = PATH_DIGINT;
      default: next_path = PATH_RESERVED;
    endcase
  end

  // Software owns consistency; the block only reports it
  always_comb begin
    next_ok = 1'b0;
    if (next_mode == MODE_DIGINT) begin
      next_ok = (next_path == PATH_DIGINT)
        && dig_en_reg[DIG_EN_B_BIT];
    end else if (next_mode == MODE_NORMAL) begin
      next_ok = (next_path == PATH_FULL || next_path == PATH_AMP_ADC)
        && !dig_en_reg[DIG_EN_B_BIT];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_MODE <= MODE_NORMAL;
      O_PATH <= PATH_FULL;
      O_CFG_OK <= 1'b1;
    end else begin
      O_MODE <= next_mode;
      O_PATH <= next_path;
      O_CFG_OK <= next_ok;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_DIGINT_B <= 1'b0;
      O_DIGINT_A <= 1'b0;
    end else begin
      O_DIGINT_B <= dig_en_reg[DIG_EN_B_BIT];
      O_DIGINT_A <= dig_en_reg[DIG_EN_A_BIT];
    end
  end

  // Channel gains
  assign gif.ind_en = mode_gain_reg[IND_EN_BIT];
  assign gif.shared_gain = mode_gain_reg[GAIN_LSB +: 2];
  assign gif.gain_234 = ch_gain_reg[CH_GAIN_LSB +: 6];

  slbcfg_gain u_gain (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .g(gif.gain)
  );

  assign O_CH_GAIN = gif.ch_gain;
endmodule

// [slbcfg_asserts.sv]
/*
  Checker for the second slot configuration bank.
  Assumes it is bound to slbcfg_top and sees only that module's ports.
*/
`timescale 1ns/1ns
module slbcfg_asserts (
  input logic I_CLK,
  input logic I_RST_N,
  input logic [slbcfg_pkg::ADDR_W-1:0] I_AWADDR,
  input logic I_AWVALID,
  input logic O_AWREADY,
  input logic [31:0] I_WDATA,
  input logic [3:0] I_WSTRB,
  input logic I_WVALID,
  input logic O_WREADY,
  input logic [4:0] O_WIN_WIDTH_US,
  input logic [9:0] O_WIN_WIDTH_CYC,
  input logic [5:0] O_WIN_COARSE_US,
  input logic [4:0] O_WIN_FINE,
  input logic [10:0] O_WIN_START_FINE,
  input logic O_GAP_EN,
  input logic [9:0] O_GAP_CYC,
  input slbcfg_pkg::slbcfg_mode_t O_MODE,
  input slbcfg_pkg::slbcfg_path_t O_PATH,
  input logic [7:0] O_CH_GAIN,
  input logic O_DIGINT_A,
  input logic O_DIGINT_B
);
  import slbcfg_pkg::*;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  function automatic slbcfg_mode_t mode_of(logic [7:0] c);
    return c == 8'h1c ? MODE_NORMAL : c == 8'h1d ? MODE_DIGINT : MODE_RESERVED;
  endfunction
  function automatic slbcfg_path_t path_of(logic [15:0] c);
    return c == 16'hada5 ? PATH_FULL : c == 16'hb065 ? PATH_AMP_ADC :
      c == 16'hae65 ? PATH_DIGINT : PATH_RESERVED;
  endfunction
  // Full-word write taken on both channels at one edge
  sequence wr_at(logic [7:0] idx);
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY &&
      I_AWADDR == {2'h0, idx, 2'h0} && I_WSTRB[1:0] == 2'h3;
  endsequence
  width_cycles_a: assert property (
    O_WIN_WIDTH_CYC == O_WIN_WIDTH_US * 10'd25)
    else $error("width cycles wrong");
  window_start_a: assert property (
    O_WIN_START_FINE == {O_WIN_COARSE_US, O_WIN_FINE})
    else $error("window start wrong");
  gap_cycles_a: assert property (
    O_GAP_CYC == (O_GAP_EN ? O_WIN_FINE * 10'd25 : 10'd0))
    else $error("gap cycles wrong");
  mode_decode_a: assert property (wr_at(IDX_MODE_GAIN) |->
    ##3 O_MODE == mode_of($past(I_WDATA[15:8], 3)))
    else $error("mode decode wrong");
  path_decode_a: assert property (wr_at(IDX_PATH) |->
    ##3 O_PATH == path_of($past(I_WDATA[15:0], 3)))
    else $error("path decode wrong");
  digint_b_a: assert property (wr_at(IDX_DIG_EN) |->
    ##3 O_DIGINT_B == $past(I_WDATA[13], 3))
    else $error("slot B enable wrong");
  digint_a_a: assert property (wr_at(IDX_DIG_EN) |->
    ##3 O_DIGINT_A == $past(I_WDATA[12], 3))
    else $error("slot A enable wrong");
  shared_gain_a: assert property (
    wr_at(IDX_MODE_GAIN) ##0 !I_WDATA[6] |->
    ##4 O_CH_GAIN == {4{$past(I_WDATA[1:0], 4)}})
    else $error("shared gain wrong");
  ch1_gain_a: assert property (
    wr_at(IDX_MODE_GAIN) ##0 I_WDATA[6] |->
    ##4 O_CH_GAIN[1:0] == $past(I_WDATA[1:0], 4))
    else $error("channel 1 gain wrong");
endmodule
bind slbcfg_top slbcfg_asserts slbcfg_asserts_inst (.I_CLK, .I_RST_N,
  .I_AWADDR, .I_AWVALID, .O_AWREADY, .I_WDATA, .I_WSTRB, .I_WVALID,
  .O_WREADY, .O_WIN_WIDTH_US, .O_WIN_WIDTH_CYC, .O_WIN_COARSE_US,
  .O_WIN_FINE, .O_WIN_START_FINE, .O_GAP_EN, .O_GAP_CYC, .O_MODE, .O_PATH,
  .O_CH_GAIN, .O_DIGINT_A, .O_DIGINT_B);

// [testbench.sv]
/*
  Self-checking bench for the second slot configuration bank.
  Assumes the bank is the only slave and answers every request.
*/
`timescale 1ns/1ns
module testbench;
  import slbcfg_pkg::*;
  logic clk = 0, rst_n = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, gap_en, dig_a, dig_b;
  logic cfg_ok;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [4:0] width_us, fine;
  logic [9:0] width_cyc, gap_cyc;
  logic [5:0] coarse;
  logic [10:0] start_fine;
  logic [7:0] ch_gain;
  slbcfg_mode_t mode;
  slbcfg_path_t path;
  logic [15:0] mdl [logic [9:0]];
  logic [7:0] modes [3] = '{8'h1c, 8'h1d, 8'h5a};
  logic [15:0] paths [4] = '{16'hada5, 16'hb065, 16'hae65, 16'h1234};
  logic [15:0] d;
  int n_fail = 0, n_checks = 0;

  slbcfg_top slbcfg_top_inst (.I_CLK(clk), .I_RST_N(rst_n),
    .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready),
    .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .O_WIN_WIDTH_US(width_us), .O_WIN_WIDTH_CYC(width_cyc),
    .O_WIN_COARSE_US(coarse), .O_WIN_FINE(fine),
    .O_WIN_START_FINE(start_fine), .O_GAP_EN(gap_en), .O_GAP_CYC(gap_cyc),
    .O_MODE(mode), .O_PATH(path), .O_CH_GAIN(ch_gain),
    .O_DIGINT_A(dig_a), .O_DIGINT_B(dig_b), .O_CFG_OK(cfg_ok));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic test_done();
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Unmapped places answer with an error and keep nothing
  task automatic wr(input logic [9:0] a, input logic [15:0] v,
      input logic [3:0] s);
    int k;
    logic ok;
    ok = mdl.exists(a);
    @(posedge clk);
    awaddr <= {a, 2'h0};
    wdata <= {16'h0, v};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (k == 40) begin
      n_fail++;
      test_done();
    end
    chk(bresp, ok ? 2'h0 : 2'h2);
    if (ok && s[0]) mdl[a][7:0] = v[7:0];
    if (ok && s[1]) mdl[a][15:8] = v[15:8];
  endtask

  task automatic rd(input logic [9:0] a);
    int k;
    logic ok;
    ok = mdl.exists(a);
    @(posedge clk);
    araddr <= {a, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (k == 40) begin
      n_fail++;
      test_done();
    end
    chk(rdata, ok ? {16'h0, mdl[a]} : 32'h0);
    chk(rresp, ok ? 2'h0 : 2'h2);
  endtask

  // Gains trail their registers by one edge, so wait three
  task automatic check_outs();
    logic [15:0] w, m, p, c, e;
    slbcfg_mode_t em;
    slbcfg_path_t ep;
    logic o;
    w = mdl[10'h3b];
    m = mdl[10'h44];
    p = mdl[10'h45];
    c = mdl[10'h55];
    e = mdl[10'h5a];
    em = m[15:8] == 8'h1c ? MODE_NORMAL :
      m[15:8] == 8'h1d ? MODE_DIGINT : MODE_RESERVED;
    ep = p == 16'hada5 ? PATH_FULL : p == 16'hb065 ? PATH_AMP_ADC :
      p == 16'hae65 ? PATH_DIGINT : PATH_RESERVED;
    // Consistency: mode, path and slot B enable all agree
    o = 1'b0;
    if (em == MODE_DIGINT) begin
      o = ep == PATH_DIGINT && mdl[10'h58][13];
    end else if (em == MODE_NORMAL) begin
      o = (ep == PATH_FULL || ep == PATH_AMP_ADC) && !mdl[10'h58][13];
    end
    repeat (3) @(posedge clk);
    chk(width_us, w[15:11]);
    chk(width_cyc, w[15:11] * 25);
    chk(coarse, w[10:5]);
    chk(fine, w[4:0]);
    chk(start_fine, w[10:5] * 32 + w[4:0]);
    chk(mode, em);
    chk(ch_gain, m[6] ? {c[11:6], m[1:0]} : {4{m[1:0]}});
    chk(path, ep);
    chk(dig_b, mdl[10'h58][13]);
    chk(dig_a, mdl[10'h58][12]);
    chk(gap_cyc, e[7] ? w[4:0] * 25 : 0);
    chk(gap_en, e[7]);
    chk(cfg_ok, o);
    // Status word is read-only, so the model is rebuilt before each read
    mdl[10'h60] = {10'h000, mdl[10'h58][13], o, em, ep};
    rd(10'h60);
  endtask

  task automatic mdl_init();
    mdl[10'h3b] = {5'h04, 6'h17, 5'h1c};
    mdl[10'h44] = 16'h1c38;
    mdl[10'h45] = 16'hada5;
    mdl[10'h55] = 16'h0;
    mdl[10'h58] = 16'h0;
    mdl[10'h5a] = 16'h0;
  endtask

  initial begin
    void'($urandom(32'h166a));
    mdl_init();
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    check_outs();
    foreach (mdl[a]) rd(a);
    for (int i = 0; i < 12; i++) begin
      wr(10'h3b, 16'($urandom), 4'h3);
      d = 16'($urandom);
      d[15:8] = modes[i % 3];
      d[6] = i[0];
      // One low-lane-only write must leave the mode code alone
      wr(10'h44, d, (i == 5) ? 4'h1 : 4'h3);
      wr(10'h45, paths[i % 4], 4'h3);
      wr(10'h55, 16'($urandom), 4'hf);
      wr(10'h58, 16'($urandom), 4'h3);
      wr(10'h5a, 16'($urandom), 4'h3);
      check_outs();
      rd(10'h44);
      rd(10'h58);
    end
    wr(10'h70, 16'hffff, 4'h3);
    wr(10'h13b, 16'h0, 4'h3);
    wr(10'h60, 16'hffff, 4'h3);
    rd(10'h70);
    rd(10'h3b);
    check_outs();
    // Settings kept consistent for digital integration, then full path
    wr(10'h44, 16'h1d00, 4'h3);
    wr(10'h45, 16'hae65, 4'h3);
    wr(10'h58, 16'h2000, 4'h3);
    check_outs();
    wr(10'h44, 16'h1c41, 4'h3);
    wr(10'h45, 16'hada5, 4'h3);
    wr(10'h58, 16'h1000, 4'h3);
    check_outs();
    // A reset in mid-run must bring every written register back
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    mdl_init();
    check_outs();
    foreach (mdl[a]) rd(a);
    test_done();
  end
endmodule
